/* src/plser_map.vh */
// constants for the parallel to lane serializer
// assumes a single 10 mhz design clock and no software-visible registers
`ifndef PLSER_MAP_VH
`define PLSER_MAP_VH
`define PLSER_BITS_PER_LANE  3'h7
`define PLSER_LANES          4
`define PLSER_WORD_W         28
`define PLSER_SLOT_W         3
`define PLSER_SLOT_LAST      3'h6
`define PLSER_CLK_HIGH_END   3'h1
`define PLSER_CLK_LOW_END    3'h4
`define PLSER_CONV_BITS      8
`define PLSER_TIE_LOW        20'h0_0000
`endif

/* src/plser_top.v */
// seven to one serializer: 28-bit word onto four lanes plus a lane clock
// assumes clk is the fast bit clock (7x the word rate) and that
// parallel_strobe_clock_in is a level sampled on clk
`timescale 1ns/10ps
`include "plser_map.vh"
module plser_top
(
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        parallel_strobe_clock_in,
   input  wire        strobe_edge_select,
   input  wire [7:0]  converter_serial_out,
   input  wire [19:0] parallel_data_in_hi,
   input  wire        in_valid,
   output wire        in_ready,
   output reg  [3:0]  lane_data,
   output reg         forwarded_lane_clock,
   output reg         word_start,
   output reg         overflow
);

   reg                       ref_q;
   reg                       edge_sel_q;
   reg                       primed_q;
   reg  [`PLSER_WORD_W-1:0]  buf_q [0:1];
   reg                       wr_ptr_q;
   reg                       rd_ptr_q;
   reg  [1:0]                count_q;
   reg  [`PLSER_WORD_W-1:0]  shift_q;
   reg  [`PLSER_SLOT_W-1:0]  slot_q;
   reg                       running_q;
   wire                      rise;
   wire                      fall;
   wire                      strobe;
   wire                      push;
   wire                      pop;
   wire                      last_slot;
   wire [`PLSER_WORD_W-1:0]  word_in;

   // upper inputs are held low by the far side; only 0..7 carry data
   assign word_in   = {parallel_data_in_hi, converter_serial_out};
   assign rise      = parallel_strobe_clock_in & ~ref_q;
   assign fall      = ~parallel_strobe_clock_in & ref_q;
   assign strobe    = primed_q & (edge_sel_q ? rise : fall);
   assign in_ready  = (count_q != 2'h2);
   assign push      = strobe & in_valid & in_ready;
   assign last_slot = (slot_q == `PLSER_SLOT_LAST);
   // a new word is loaded at once when idle, else when the lane frame wraps; at most once per word period
   assign pop       = (count_q != 2'h0) & (~running_q | last_slot);

   // lane bit k of lane L carries word bit 7*L + k, lsb first
   function lane_bit;
      input [`PLSER_WORD_W-1:0] w;
      input [1:0]               lane;
      input [`PLSER_SLOT_W-1:0] slot;
      reg   [4:0]               idx;
      begin
         idx      = {lane, 3'h0} - {3'h0, lane} + {2'h0, slot};
         lane_bit = w[idx];
      end
   endfunction

   // lane clock slots: two high, three low, two high
   function phase_high;
      input [`PLSER_SLOT_W-1:0] slot;
      begin
         phase_high = (slot <= `PLSER_CLK_HIGH_END) |
                      (slot >  `PLSER_CLK_LOW_END);
      end
   endfunction

   always @(posedge clk)
   begin
      if (sys_rst)
         ref_q <= 1'b0;
      else
         ref_q <= parallel_strobe_clock_in;
   end

   // the detector holds no real sample on the first edge after release,
   // so strobes are masked for that edge to avoid a false capture
   always @(posedge clk)
   begin
      if (sys_rst)
         primed_q <= 1'b0;
      else
         primed_q <= 1'b1;
   end

   // strap taken after release, clean level from then on
   always @(posedge clk)
   begin
      if (sys_rst)
         edge_sel_q <= 1'b0;
      else
         edge_sel_q <= strobe_edge_select;
   end

   // two-entry buffer so a word strobed mid-frame waits, not lost
   always @(posedge clk)
   begin
      if (push)
         buf_q[wr_ptr_q] <= word_in;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
         wr_ptr_q <= 1'b0;
      else if (push)
         wr_ptr_q <= ~wr_ptr_q;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
         rd_ptr_q <= 1'b0;
      else if (pop)
         rd_ptr_q <= ~rd_ptr_q;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
         count_q <= 2'h0;
      else
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
   end

   // a strobe while full drops its word; flagged for one cycle
   always @(posedge clk)
   begin
      if (sys_rst)
         overflow <= 1'b0;
      else
         overflow <= strobe & in_valid & ~in_ready;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         shift_q   <= {`PLSER_WORD_W{1'b0}};
         slot_q    <= {`PLSER_SLOT_W{1'b0}};
         running_q <= 1'b0;
      end
      else if (pop)
      begin
         shift_q   <= buf_q[rd_ptr_q];
         slot_q    <= {`PLSER_SLOT_W{1'b0}};
         running_q <= 1'b1;
      end
      else if (running_q)
      begin
         if (last_slot)
            running_q <= 1'b0;
         else
            slot_q <= slot_q + 3'h1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `PLSER_LANES; g = g + 1)
      begin : g_lane
         localparam [1:0] LANE_IDX = g;
         always @(posedge clk)
         begin
            if (sys_rst)
               lane_data[g] <= 1'b0;
            else if (running_q)
               lane_data[g] <= lane_bit(shift_q, LANE_IDX, slot_q);
            else
               lane_data[g] <= 1'b0;
         end
      end
   endgenerate

   // lane clock high for slots 0-1, low for 2-4, high for 5-6
   always @(posedge clk)
   begin
      if (sys_rst)
         forwarded_lane_clock <= 1'b0;
      else
         forwarded_lane_clock <= running_q & phase_high(slot_q);
   end

   // marks slot 0 so the receiver can frame the seven bits
   always @(posedge clk)
   begin
      if (sys_rst)
         word_start <= 1'b0;
      else
         word_start <= running_q & (slot_q == 3'h0);
   end

endmodule

/* verif/plser_asserts.sv */
// serializer port checks
// needs: strobe seen as a level on clk
`timescale 1ns/10ps
module plser_chk
(
   input wire        clk,
   input wire        sys_rst,
   input wire        parallel_strobe_clock_in,
   input wire        strobe_edge_select,
   input wire [7:0]  converter_serial_out,
   input wire [19:0] parallel_data_in_hi,
   input wire        in_valid,
   input wire        in_ready,
   input wire [3:0]  lane_data,
   input wire        forwarded_lane_clock,
   input wire        word_start,
   input wire        overflow
);
   wire        r = parallel_strobe_clock_in;
   wire        s = strobe_edge_select;
   wire        t = in_valid && in_ready;
   wire        z = word_start;
   logic [27:0] a_q, b_q, c_q;
   // word history: slot 0 shows three edges after the capture edge
   always @(posedge clk)
      {c_q, b_q, a_q} <= {b_q, a_q, parallel_data_in_hi, converter_serial_out};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_gap; z |=> !z [*6]; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   property p_clk; z |-> forwarded_lane_clock [*2] ##1
      !forwarded_lane_clock [*3] ##1 forwarded_lane_clock [*2]; endproperty
   a_clk: assert property (p_clk) else $error("lane clock");
   // first edge after release has no detector sample: no capture there
   property p_fal; $fell(r) && t && !s && !$past(sys_rst) |-> ##3 z;
   endproperty
   a_fal: assert property (p_fal) else $error("fall");
   property p_ris; $rose(r) && t && s && !$past(sys_rst) |-> ##3 z;
   endproperty
   a_ris: assert property (p_ris) else $error("rise");
   property p_odd; $rose(r) && !s || $fell(r) && s |-> ##3 !z; endproperty
   a_odd: assert property (p_odd) else $error("edge");
   property p_sl0; z |-> lane_data == {c_q[21], c_q[14], c_q[7], c_q[0]};
   endproperty
   a_sl0: assert property (p_sl0) else $error("slot");
   property p_ovf; overflow |-> !$past(in_ready); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow");
   c_fal: cover property ($fell(r) && t && !s);
   c_ris: cover property ($rose(r) && t && s);
   c_two: cover property (z ##7 z);
endmodule
bind plser_top plser_chk plser_chk_inst (.*);

/* verif/plser_rx.sv */
// lane receiver model
// needs: word_start on slot 0
`timescale 1ns/10ps
module plser_rx
(
   input  wire         clk,
   input  wire  [3:0]  lane_data,
   input  wire         word_start,
   output logic [27:0] word,
   output logic        got
);
   int n = 7;
   always @(posedge clk)
   begin
      if (word_start) n = 0;
      for (int i = 0; i < 4; i++) if (n < 7) word[7*i+n] <= lane_data[i];
      got <= n == 6;
      if (n < 7) n++;
   end
endmodule

/* verif/plser_tb.sv */
// bench: free strobe, data driver, word checks
// needs: the receiver model on the lanes
`timescale 1ns/10ps
module testbench;
   logic        clk = 0, rst = 1, rf = 1, sel = 0, got, ws;
   logic [7:0]  d = 8'h00;
   logic [3:0]  ln;
   logic [27:0] word;
   int          cnt = 0, failures = 0, compares = 0;
   plser_top plser_top_inst (.clk(clk), .sys_rst(rst),
      .parallel_strobe_clock_in(rf), .strobe_edge_select(sel),
      .converter_serial_out(d), .parallel_data_in_hi(20'h0_0000),
      .in_valid(1'b1), .in_ready(), .lane_data(ln),
      .forwarded_lane_clock(), .word_start(ws), .overflow());
   // one clock serves both ends of the link
   plser_rx plser_rx_inst (.clk(clk), .lane_data(ln), .word_start(ws),
      .word(word), .got(got));
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      cnt <= (cnt + 1) % 7;
      rf <= cnt < 3;
   end
   task check(input logic [27:0] s, e);
      compares++;
      if (s !== e) failures++;
      if (s !== e) $display("[FAIL] word exp %h got %h", e, s);
   endtask
   task final_report(input int h);
      failures += h;
      if (failures == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // release on the clock edge that raises the strobe (cnt back to 0), three edges before it falls
   task do_reset(input logic s);
      rst <= 1;
      sel <= s;
      repeat (12) @(posedge clk);
      repeat (7) if (cnt != 0) @(posedge clk);
      rst <= 0;
   endtask
   // third frame after the change is the first one surely holding v
   task xfer(input logic [7:0] v);
      int g;
      g = 0;
      d <= v;
      repeat (40) if (g < 3) @(posedge clk) g += got === 1'b1;
      if (g < 3)
         final_report(1);
      else
         check(word, {20'h0_0000, v});
   endtask
   task t_fall;
      do_reset(0);
      xfer(8'hA5);
      xfer(8'h5A);
   endtask
   task t_rise;
      do_reset(1);
      xfer(8'h81);
      xfer(8'h7E);
   endtask
   initial
   begin
      t_fall();
      t_rise();
      final_report(0);
   end
endmodule
